// ===== rtl/vic_consts.svh
// Register indices, field positions, reset values and decode constants
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// Register indices; byte address is index times four
`define VIC_IDX_INPUT 4'h0
`define VIC_IDX_MODE 4'h1
`define VIC_IDX_ENH 4'h2
`define VIC_IDX_STATUS 4'h3

// Reset values
`define VIC_RST_INPUT 8'h00
`define VIC_RST_MODE 8'h00
`define VIC_RST_ENH 8'h00

// Writable bit masks, reserved bits held at zero
`define VIC_MASK_INPUT 8'hFF
`define VIC_MASK_MODE 8'hBF
`define VIC_MASK_ENH 8'h1F

// Input register fields
`define VIC_SRC_MSB 3
`define VIC_SRC_LSB 0
`define VIC_STD_MSB 7
`define VIC_STD_LSB 4

// Mode register fields
`define VIC_QUAL_MSB 1
`define VIC_QUAL_LSB 0
`define VIC_SQP_BIT 2
`define VIC_DIFF_BIT 3
`define VIC_QSC_BIT 4
`define VIC_PRO_BIT 5
`define VIC_ARD_BIT 7

// Enhancement register fields
`define VIC_PEAK_MSB 2
`define VIC_PEAK_LSB 0
`define VIC_CORE_MSB 4
`define VIC_CORE_LSB 3

// Status register: sticky reacquire flag, write one to clear
`define VIC_STAT_REACQ_BIT 7

// Source codes
`define VIC_SRC_CVBS_LAST 4'h5
`define VIC_SRC_YC_FIRST 4'h6
`define VIC_SRC_YC_LAST 4'h8
`define VIC_SRC_YUV_A 4'h9
`define VIC_SRC_YUV_B 4'hA

// Standard codes
`define VIC_STD_AUTO_LAST 4'h3
`define VIC_STD_NTSC_LAST 4'h7
`define VIC_STD_PAL_BGHID 4'h8
`define VIC_STD_PAL_N 4'h9
`define VIC_STD_PAL_M_LAST 4'hB
`define VIC_STD_PAL_CN_LAST 4'hD

// Peaking gains in hundredths of a dB
`define VIC_DB_P450 12'sd450
`define VIC_DB_P925 12'sd925
`define VIC_DB_P575 12'sd575
`define VIC_DB_P125 12'sd125
`define VIC_DB_P330 12'sd330
`define VIC_DB_ZERO 12'sd0
`define VIC_DB_M125 -12'sd125
`define VIC_DB_M175 -12'sd175
`define VIC_DB_M300 -12'sd300
`define VIC_DB_M800 -12'sd800

// Coring thresholds above black
`define VIC_CORE_T0 6'h00
`define VIC_CORE_T1 6'h08
`define VIC_CORE_T2 6'h10
`define VIC_CORE_T3 6'h20

`endif

// ===== rtl/vic_pkg.sv
// Types shared by the video input configuration block
package vic_pkg;

    typedef enum logic [1:0] {
        FMT_COMPOSITE,
        FMT_SVIDEO,
        FMT_COMPONENT,
        FMT_NONE
    } vic_fmt_t;

    typedef enum logic [2:0] {
        STD_NTSC_M,
        STD_NTSC_443,
        STD_PAL_BGHID,
        STD_PAL_N,
        STD_PAL_M,
        STD_PAL_CN,
        STD_NONE
    } vic_std_t;

    typedef enum logic [1:0] {
        QUAL_BROADCAST,
        QUAL_TV,
        QUAL_VCR,
        QUAL_SURVEILLANCE
    } vic_qual_t;

endpackage : vic_pkg

// ===== rtl/vic_decode.sv
// Combinational decode of source, standard, peaking and coring codes
`include "vic_consts.svh"

module vic_decode (
    input wire logic [3:0] src_code,
    input wire logic [3:0] std_code,
    input wire logic [2:0] peak_code,
    input wire logic [1:0] core_code,
    output vic_pkg::vic_fmt_t fmt,
    output logic [5:0] luma_sel,
    output logic [5:0] chroma_sel,
    output logic [5:0] u_sel,
    output logic [5:0] v_sel,
    output logic auto_detect,
    output vic_pkg::vic_std_t pal_std,
    output vic_pkg::vic_std_t ntsc_std,
    output logic pedestal,
    output logic signed [11:0] peak_comp,
    output logic signed [11:0] peak_svid,
    output logic [5:0] core_thr
);

    // One-hot select of analog input n (0 based)
    function automatic logic [5:0] vic_onehot(input logic [3:0] n);
        vic_onehot = 6'h01 << n[2:0];
    endfunction : vic_onehot

    // Source decode
    wire is_cvbs = (src_code <= `VIC_SRC_CVBS_LAST);
    wire is_yc = (src_code >= `VIC_SRC_YC_FIRST) && (src_code <= `VIC_SRC_YC_LAST);
    wire is_yuv_a = (src_code == `VIC_SRC_YUV_A);
    wire is_yuv_b = (src_code == `VIC_SRC_YUV_B);
    wire [3:0] yc_idx = src_code - `VIC_SRC_YC_FIRST;

    assign fmt = is_cvbs ? vic_pkg::FMT_COMPOSITE :
                 is_yc ? vic_pkg::FMT_SVIDEO :
                 (is_yuv_a || is_yuv_b) ? vic_pkg::FMT_COMPONENT : vic_pkg::FMT_NONE;
    assign luma_sel = is_cvbs ? vic_onehot(src_code) :
                      is_yc ? vic_onehot(yc_idx) :
                      is_yuv_a ? vic_onehot(4'h0) :
                      is_yuv_b ? vic_onehot(4'h1) : 6'h00;
    assign chroma_sel = is_yc ? vic_onehot(yc_idx + 4'h3) : 6'h00;
    assign u_sel = is_yuv_a ? vic_onehot(4'h3) :
                   is_yuv_b ? vic_onehot(4'h2) : 6'h00;
    assign v_sel = is_yuv_a ? vic_onehot(4'h4) :
                   is_yuv_b ? vic_onehot(4'h5) : 6'h00;

    // Standard decode
    wire std_auto = (std_code <= `VIC_STD_AUTO_LAST);
    wire std_ntsc = !std_auto && (std_code <= `VIC_STD_NTSC_LAST);
    wire std_pal_m = (std_code > `VIC_STD_PAL_N) && (std_code <= `VIC_STD_PAL_M_LAST);
    wire std_pal_cn = (std_code > `VIC_STD_PAL_M_LAST) && (std_code <= `VIC_STD_PAL_CN_LAST);

    assign auto_detect = std_auto;
    assign ntsc_std = (std_auto || (std_ntsc && !std_code[1])) ? vic_pkg::STD_NTSC_M :
                      std_ntsc ? vic_pkg::STD_NTSC_443 : vic_pkg::STD_NONE;
    assign pal_std = std_auto ? (std_code[1] ? vic_pkg::STD_PAL_N : vic_pkg::STD_PAL_BGHID) :
                     (std_code == `VIC_STD_PAL_BGHID) ? vic_pkg::STD_PAL_BGHID :
                     (std_code == `VIC_STD_PAL_N) ? vic_pkg::STD_PAL_N :
                     std_pal_m ? vic_pkg::STD_PAL_M :
                     std_pal_cn ? vic_pkg::STD_PAL_CN : vic_pkg::STD_NONE;
    // Code 9 always carries pedestal, code 8 and codes above 13 never; elsewhere the low code bit does
    assign pedestal = (std_code == `VIC_STD_PAL_N) ? 1'b1 :
                      (std_code == `VIC_STD_PAL_BGHID) ? 1'b0 :
                      (std_code > `VIC_STD_PAL_CN_LAST) ? 1'b0 : std_code[0];

    // Luma peaking gains around the subcarrier
    always_comb begin
        case (peak_code)
            3'h0, 3'h1: begin
                peak_comp = `VIC_DB_P450;
                peak_svid = `VIC_DB_P925;
            end
            3'h2: begin
                peak_comp = `VIC_DB_P450;
                peak_svid = `VIC_DB_P575;
            end
            3'h3: begin
                peak_comp = `VIC_DB_P125;
                peak_svid = `VIC_DB_P330;
            end
            3'h5: begin
                peak_comp = `VIC_DB_M125;
                peak_svid = `VIC_DB_M300;
            end
            3'h6: begin
                peak_comp = `VIC_DB_M175;
                peak_svid = `VIC_DB_M800;
            end
            3'h7: begin
                peak_comp = `VIC_DB_M300;
                peak_svid = `VIC_DB_M800;
            end
            default: begin
                peak_comp = `VIC_DB_ZERO;
                peak_svid = `VIC_DB_ZERO;
            end
        endcase
    end

    // Coring threshold above black level
    assign core_thr = (core_code == 2'h1) ? `VIC_CORE_T1 :
                      (core_code == 2'h2) ? `VIC_CORE_T2 :
                      (core_code == 2'h3) ? `VIC_CORE_T3 : `VIC_CORE_T0;

endmodule : vic_decode

// ===== rtl/vic_regs.sv
// APB register bank and registered control outputs for video input setup
//
// Our own choice: register access over APB.
`include "vic_consts.svh"

module vic_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output vic_pkg::vic_fmt_t input_format,
    output logic [5:0] luma_input_sel,
    output logic [5:0] chroma_input_sel,
    output logic [5:0] comp_u_input_sel,
    output logic [5:0] comp_v_input_sel,
    output logic differential_input_enable,
    output logic auto_detect_enable,
    output vic_pkg::vic_std_t pal_standard,
    output vic_pkg::vic_std_t ntsc_standard,
    output logic pedestal_enable,
    output vic_pkg::vic_qual_t input_quality_select,
    output logic square_pixel_enable,
    output logic quad_subcarrier_sampling,
    output logic line_locked_pixel_clock_4fsc,
    output logic professional_component_enable,
    output logic reacquire_req,
    output logic [2:0] luma_peaking_mode,
    output logic signed [11:0] luma_peak_composite_cdb,
    output logic signed [11:0] luma_peak_svideo_cdb,
    output logic luma_coring_enable,
    output logic [5:0] luma_coring_threshold
);

    // Register storage
    logic [7:0] input_source_and_standard_r;
    logic [7:0] video_mode_selection_r;
    logic [7:0] luma_enhancement_control_r;
    logic reacq_seen_r;
    logic reacquire_req_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // Registered decoded outputs
    vic_pkg::vic_fmt_t fmt_r;
    logic [5:0] luma_sel_r;
    logic [5:0] chroma_sel_r;
    logic [5:0] u_sel_r;
    logic [5:0] v_sel_r;
    logic auto_r;
    vic_pkg::vic_std_t pal_r;
    vic_pkg::vic_std_t ntsc_r;
    logic ped_r;
    logic signed [11:0] peak_comp_r;
    logic signed [11:0] peak_svid_r;
    logic [5:0] core_thr_r;

    // Field views
    wire [3:0] src_code = input_source_and_standard_r[`VIC_SRC_MSB:`VIC_SRC_LSB];
    wire [3:0] std_code = input_source_and_standard_r[`VIC_STD_MSB:`VIC_STD_LSB];
    wire [2:0] peak_code = luma_enhancement_control_r[`VIC_PEAK_MSB:`VIC_PEAK_LSB];
    wire [1:0] core_code = luma_enhancement_control_r[`VIC_CORE_MSB:`VIC_CORE_LSB];
    wire auto_reacquire_disable = video_mode_selection_r[`VIC_ARD_BIT];

    // Address decode
    wire [ADDR_W-3:0] word_idx = paddr[ADDR_W-1:2];
    wire sel_input = (word_idx == (ADDR_W-2)'(`VIC_IDX_INPUT));
    wire sel_mode = (word_idx == (ADDR_W-2)'(`VIC_IDX_MODE));
    wire sel_enh = (word_idx == (ADDR_W-2)'(`VIC_IDX_ENH));
    wire sel_status = (word_idx == (ADDR_W-2)'(`VIC_IDX_STATUS));
    wire aligned = (paddr[1:0] == 2'h0);
    wire mapped = aligned && (sel_input || sel_mode || sel_enh || sel_status);

    // Bus phases; zero wait states so access always completes
    wire setup_ph = psel && !penable;
    wire wr_acc = psel && penable && pready && pwrite && mapped;
    wire wr_input = wr_acc && sel_input;
    wire wr_mode = wr_acc && sel_mode;
    wire wr_enh = wr_acc && sel_enh;
    wire wr_status = wr_acc && sel_status;

    // Source change detect on write to input register
    wire [3:0] new_src = pwdata[`VIC_SRC_MSB:`VIC_SRC_LSB];
    wire src_change = wr_input && (new_src != src_code);
    wire reacq_fire = src_change && !auto_reacquire_disable;
    wire reacq_clear = wr_status && pwdata[`VIC_STAT_REACQ_BIT];

    // Unlisted codes shown in status; their routing is left idle
    wire src_bad = (src_code > `VIC_SRC_YUV_B);
    wire std_bad = (std_code > `VIC_STD_PAL_CN_LAST);

    // Status register view of the block's own state
    wire [7:0] status_view = {reacq_seen_r, 1'b0, src_bad, std_bad,
                              1'b0, fmt_r, auto_r};

    // Read mux
    wire [7:0] rd_byte = sel_input ? input_source_and_standard_r :
                         sel_mode ? video_mode_selection_r :
                         sel_enh ? luma_enhancement_control_r :
                         sel_status ? status_view : 8'h00;
    wire [31:0] rd_word = mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    // Decode of codes into routing, standard and filter settings
    vic_pkg::vic_fmt_t dec_fmt;
    logic [5:0] dec_luma;
    logic [5:0] dec_chroma;
    logic [5:0] dec_u;
    logic [5:0] dec_v;
    logic dec_auto;
    vic_pkg::vic_std_t dec_pal;
    vic_pkg::vic_std_t dec_ntsc;
    logic dec_ped;
    logic signed [11:0] dec_peak_comp;
    logic signed [11:0] dec_peak_svid;
    logic [5:0] dec_core;

    vic_decode u_decode (
        .src_code(src_code),
        .std_code(std_code),
        .peak_code(peak_code),
        .core_code(core_code),
        .fmt(dec_fmt),
        .luma_sel(dec_luma),
        .chroma_sel(dec_chroma),
        .u_sel(dec_u),
        .v_sel(dec_v),
        .auto_detect(dec_auto),
        .pal_std(dec_pal),
        .ntsc_std(dec_ntsc),
        .pedestal(dec_ped),
        .peak_comp(dec_peak_comp),
        .peak_svid(dec_peak_svid),
        .core_thr(dec_core)
    );

    // Input source and standard register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_source_and_standard_r <= `VIC_RST_INPUT;
        end else if (wr_input) begin
            input_source_and_standard_r <= pwdata[7:0] & `VIC_MASK_INPUT;
        end
    end

    // Video mode register, reserved bit held at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_mode_selection_r <= `VIC_RST_MODE;
        end else if (wr_mode) begin
            video_mode_selection_r <= pwdata[7:0] & `VIC_MASK_MODE;
        end
    end

    // Luma enhancement register, reserved bits held at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            luma_enhancement_control_r <= `VIC_RST_ENH;
        end else if (wr_enh) begin
            luma_enhancement_control_r <= pwdata[7:0] & `VIC_MASK_ENH;
        end
    end

    // Reacquire pulse and sticky flag; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reacquire_req_r <= 1'b0;
            reacq_seen_r <= 1'b0;
        end else begin
            reacquire_req_r <= reacq_fire;
            reacq_seen_r <= reacq_fire || (reacq_seen_r && !reacq_clear);
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_r <= !mapped;
        end
    end

    // Decoded settings registered for the datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_r <= vic_pkg::FMT_COMPOSITE;
            luma_sel_r <= 6'h00;
            chroma_sel_r <= 6'h00;
            u_sel_r <= 6'h00;
            v_sel_r <= 6'h00;
            auto_r <= 1'b0;
            pal_r <= vic_pkg::STD_NONE;
            ntsc_r <= vic_pkg::STD_NONE;
            ped_r <= 1'b0;
            peak_comp_r <= `VIC_DB_ZERO;
            peak_svid_r <= `VIC_DB_ZERO;
            core_thr_r <= `VIC_CORE_T0;
        end else begin
            fmt_r <= dec_fmt;
            luma_sel_r <= dec_luma;
            chroma_sel_r <= dec_chroma;
            u_sel_r <= dec_u;
            v_sel_r <= dec_v;
            auto_r <= dec_auto;
            pal_r <= dec_pal;
            ntsc_r <= dec_ntsc;
            ped_r <= dec_ped;
            peak_comp_r <= dec_peak_comp;
            peak_svid_r <= dec_peak_svid;
            core_thr_r <= dec_core;
        end
    end

    // Bus outputs
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // Routing and standard outputs
    assign input_format = fmt_r;
    assign luma_input_sel = luma_sel_r;
    assign chroma_input_sel = chroma_sel_r;
    assign comp_u_input_sel = u_sel_r;
    assign comp_v_input_sel = v_sel_r;
    assign auto_detect_enable = auto_r;
    assign pal_standard = pal_r;
    assign ntsc_standard = ntsc_r;
    assign pedestal_enable = ped_r;

    // Mode bits straight from the mode register; reacquire pulse from its own flop
    assign input_quality_select =
        vic_pkg::vic_qual_t'(video_mode_selection_r[`VIC_QUAL_MSB:`VIC_QUAL_LSB]);
    assign square_pixel_enable = video_mode_selection_r[`VIC_SQP_BIT];
    assign differential_input_enable = video_mode_selection_r[`VIC_DIFF_BIT];
    assign quad_subcarrier_sampling = video_mode_selection_r[`VIC_QSC_BIT];
    assign line_locked_pixel_clock_4fsc = video_mode_selection_r[`VIC_QSC_BIT];
    assign professional_component_enable = video_mode_selection_r[`VIC_PRO_BIT];
    assign reacquire_req = reacquire_req_r;

    // Luma filter outputs
    assign luma_peaking_mode = peak_code;
    assign luma_peak_composite_cdb = peak_comp_r;
    assign luma_peak_svideo_cdb = peak_svid_r;
    assign luma_coring_enable = (core_code != 2'h0);
    assign luma_coring_threshold = core_thr_r;

endmodule : vic_regs

// ===== verif/vic_regs_monitor.sv
// Checker of control outputs against register writes
module vic_regs_monitor #(
    parameter int ADDR_W = 8
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input vic_pkg::vic_fmt_t input_format,
    input logic [5:0] luma_input_sel,
    input logic [5:0] chroma_input_sel,
    input logic [5:0] comp_u_input_sel,
    input logic [5:0] comp_v_input_sel,
    input logic auto_detect_enable,
    input vic_pkg::vic_std_t pal_standard,
    input vic_pkg::vic_std_t ntsc_standard,
    input logic pedestal_enable,
    input logic reacquire_req,
    input logic signed [11:0] luma_peak_composite_cdb,
    input logic signed [11:0] luma_peak_svideo_cdb,
    input logic luma_coring_enable,
    input logic [5:0] luma_coring_threshold
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [7:0] in_sh_r;
    logic ase_sh_r;
    logic [1:0] core_sh_r;
    logic [23:0] gain_sh_r;
    vic_pkg::vic_std_t pal_exp;
    // Completed writes per register
    wire wr_done = psel && penable && pready && pwrite;
    wire wr0 = wr_done && paddr == ADDR_W'(8'h00);
    wire wr1 = wr_done && paddr == ADDR_W'(8'h04);
    wire wr2 = wr_done && paddr == ADDR_W'(8'h08);
    wire [3:0] src = in_sh_r[3:0];
    wire [3:0] std = in_sh_r[7:4];
    // Composite and S-video gain, 0.01 dB
    function automatic logic [23:0] gain_of(input logic [2:0] c);
        case (c)
            3'h0, 3'h1: return 24'h1C_239D;
            3'h2: return 24'h1C_223F;
            3'h3: return 24'h07_D14A;
            3'h4: return 24'h00_0000;
            3'h5: return 24'hF8_3ED4;
            3'h6: return 24'hF5_1CE0;
            default: return 24'hED_4CE0;
        endcase
    endfunction : gain_of
    // Last written values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_sh_r <= 8'h00;
            ase_sh_r <= 1'b0;
            core_sh_r <= 2'h0;
            gain_sh_r <= 24'h00_0000;
        end else begin
            if (wr0) in_sh_r <= pwdata[7:0];
            if (wr1) ase_sh_r <= pwdata[7];
            if (wr2) {core_sh_r, gain_sh_r} <= {pwdata[4:3], gain_of(pwdata[2:0])};
        end
    end
    // Forced PAL variant
    assign pal_exp = std == 4'h8 ? vic_pkg::STD_PAL_BGHID : std == 4'h9 ? vic_pkg::STD_PAL_N :
        std < 4'hC ? vic_pkg::STD_PAL_M : vic_pkg::STD_PAL_CN;

    a_cvbs_route: assert property (wr0 && pwdata[3:0] < 4'h6 |-> ##2
        input_format == vic_pkg::FMT_COMPOSITE && luma_input_sel == (6'h01 << src)
        && chroma_input_sel == 6'h00) else $error("composite routing wrong");
    a_yc_route: assert property (wr0 && pwdata[3:0] inside {[4'h6:4'h8]} |-> ##2
        input_format == vic_pkg::FMT_SVIDEO && luma_input_sel == (6'h01 << (src - 4'h6))
        && chroma_input_sel == (6'h01 << (src - 4'h3))) else $error("luma chroma routing wrong");
    a_yuv_route: assert property (wr0 && pwdata[3:0] inside {4'h9, 4'hA} |-> ##2
        input_format == vic_pkg::FMT_COMPONENT && {luma_input_sel, comp_u_input_sel,
        comp_v_input_sel} == (src == 4'h9 ? 18'h0_1210 : 18'h0_2120))
        else $error("component routing wrong");
    a_auto_std: assert property (wr0 && pwdata[7:4] < 4'h4 |-> ##2 auto_detect_enable
        && ntsc_standard == vic_pkg::STD_NTSC_M && pedestal_enable == std[0] && pal_standard
        == (std[1] ? vic_pkg::STD_PAL_N : vic_pkg::STD_PAL_BGHID)) else $error("auto mode wrong");
    a_ntsc_force: assert property (wr0 && pwdata[7:4] inside {[4'h4:4'h7]} |-> ##2
        !auto_detect_enable && pal_standard == vic_pkg::STD_NONE && pedestal_enable == std[0]
        && ntsc_standard == (std[1] ? vic_pkg::STD_NTSC_443 : vic_pkg::STD_NTSC_M))
        else $error("forced NTSC wrong");
    a_pal_force: assert property (wr0 && pwdata[7:4] inside {[4'h8:4'hD]} |-> ##2
        !auto_detect_enable && ntsc_standard == vic_pkg::STD_NONE && pal_standard == pal_exp
        && pedestal_enable == (std != 4'h8 && std[0])) else $error("forced PAL wrong");
    a_reacq_pulse: assert property (wr0 && pwdata[3:0] != src && !ase_sh_r |=>
        reacquire_req ##1 !reacquire_req) else $error("reacquire pulse missing");
    a_reacq_quiet: assert property (wr0 && (pwdata[3:0] == src || ase_sh_r) |=>
        !reacquire_req) else $error("reacquire without cause");
    a_peak_gain: assert property (wr2 |-> ##2
        {luma_peak_composite_cdb, luma_peak_svideo_cdb} == gain_sh_r) else $error("gain wrong");
    a_core_thr: assert property (wr2 |-> ##2 luma_coring_enable == (core_sh_r != 2'h0)
        && luma_coring_threshold == (core_sh_r == 2'h0 ? 6'h00 : 6'h04 << core_sh_r))
        else $error("coring threshold wrong");
endmodule : vic_regs_monitor

bind vic_regs vic_regs_monitor #(.ADDR_W(ADDR_W)) mon_u (.*);

// ===== verif/vic_src_model.sv
// Six analog sources seen through the block's input selects
module vic_src_model (
    input logic pclk,
    input logic presetn,
    input logic [5:0] luma_sel,
    input logic [5:0] chroma_sel,
    output logic [7:0] luma_pick,
    output logic [7:0] chroma_pick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] phase_r;
    // Moving picture content
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) phase_r <= 5'h00;
        else phase_r <= phase_r + 5'h01;
    end
    // Input number plus one on top bits; inverse when unselected
    always_comb begin
        luma_pick = ~{3'h0, phase_r};
        chroma_pick = ~{3'h0, phase_r};
        for (int k = 0; k < 6; k++) begin
            if (luma_sel[k]) luma_pick = {3'(k + 1), phase_r};
            if (chroma_sel[k]) chroma_pick = {3'(k + 1), phase_r};
        end
    end
endmodule : vic_src_model

// ===== verif/vic_regs_tb.sv
// Self-checking bench for the video input configuration registers
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", n, e, a); end end

module vic_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {string nm; logic [31:0] exp; logic err;} vic_note_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, dif, aut, ped, sqp, qsc, line_locked_pixel_clock, pro, racq, cen;
    vic_pkg::vic_fmt_t fmt;
    vic_pkg::vic_std_t pal, nts;
    vic_pkg::vic_qual_t qual;
    logic [5:0] ls, cs, us, vs, thr;
    logic [2:0] pm;
    logic signed [11:0] gc, gs;
    logic [7:0] lp, cp;
    int bad_count = 0, num_checks = 0, racq_seen = 0, seed = 51;
    int pgc[8] = '{450, 450, 450, 125, 0, -125, -175, -300};
    int pgs[8] = '{925, 925, 575, 330, 0, -300, -800, -800};
    vic_note_t notes[$];

    vic_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_format(fmt), .luma_input_sel(ls),
        .chroma_input_sel(cs), .comp_u_input_sel(us), .comp_v_input_sel(vs),
        .differential_input_enable(dif), .auto_detect_enable(aut), .pal_standard(pal),
        .ntsc_standard(nts), .pedestal_enable(ped), .input_quality_select(qual),
        .square_pixel_enable(sqp), .quad_subcarrier_sampling(qsc),
        .line_locked_pixel_clock_4fsc(line_locked_pixel_clock), .professional_component_enable(pro),
        .reacquire_req(racq), .luma_peaking_mode(pm), .luma_peak_composite_cdb(gc),
        .luma_peak_svideo_cdb(gs), .luma_coring_enable(cen), .luma_coring_threshold(thr));
    vic_src_model src_u (.pclk, .presetn, .luma_sel(ls), .chroma_sel(cs),
        .luma_pick(lp), .chroma_pick(cp));

    always #25 pclk = ~pclk;
    always @(posedge pclk) if (racq === 1'b1) racq_seen++;
    // Reads against the oldest note
    always @(posedge pclk) begin
        vic_note_t n;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            n = notes.pop_front();
            `CHK(n.nm, n.exp, prdata)
            `CHK(n.nm, n.err, pslverr)
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e, input logic r);
        notes.push_back('{nm, {24'h00_0000, e}, r});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    // Write, then wait for decode
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
        repeat (2) @(posedge pclk);
        #1;
    endtask : wr

    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        logic [7:0] m;
        logic [5:0] el, ec, eu, ev;
        logic [2:0] ep, en;
        logic [1:0] ef;
        int s, ps, n0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        `CHK("reset route", {vic_pkg::FMT_COMPOSITE, 6'h01}, {fmt, ls})
        `CHK("reset std", {1'b1, vic_pkg::STD_PAL_BGHID, vic_pkg::STD_NTSC_M}, {aut, pal, nts})
        for (int a = 0; a < 3; a++) rd("reset value", 8'(a * 4), 8'h00, 1'b0);
        // Mode bits under forced NTSC
        wr(8'h00, 8'h40);
        for (int k = 0; k < 4; k++) begin
            m = {2'b00, 6'($random(seed))};
            m[1:0] = 2'(k);
            wr(8'h04, m);
            `CHK("quality", vic_pkg::vic_qual_t'(m[1:0]), qual)
            `CHK("mode bits", {m[2], m[3], m[4], m[4], m[5]}, {sqp, dif, qsc, line_locked_pixel_clock, pro})
            rd("mode readback", 8'h04, m, 1'b0);
        end
        wr(8'h04, 8'h00);
        // Source codes 0 to 10 and standard codes 0 to 13
        ps = 0;
        for (int i = 0; i < 14; i++) begin
            s = i % 11;
            n0 = racq_seen;
            wr(8'h00, {4'(i), 4'(s)});
            `CHK("reacquire", (s != ps) ? 1 : 0, racq_seen - n0)
            {el, ec, eu, ev} = 24'h00_0000;
            if (s < 6) {ef, el} = {vic_pkg::FMT_COMPOSITE, 6'h01 << s};
            else if (s < 9) {ef, el, ec} = {vic_pkg::FMT_SVIDEO, 6'h01 << (s - 6), 6'h01 << (s - 3)};
            else {ef, el, eu, ev} = {vic_pkg::FMT_COMPONENT, s == 9 ? 18'h0_1210 : 18'h0_2120};
            `CHK("route", {ef, el, ec, eu, ev}, {fmt, ls, cs, us, vs})
            if (s < 9) `CHK("source pick", 3'(s < 6 ? s + 1 : s - 5), lp[7:5])
            {ep, en} = {2{vic_pkg::STD_NONE}};
            if (i < 4) {ep, en} = {i[1] ? vic_pkg::STD_PAL_N : vic_pkg::STD_PAL_BGHID, vic_pkg::STD_NTSC_M};
            else if (i < 8) en = i[1] ? vic_pkg::STD_NTSC_443 : vic_pkg::STD_NTSC_M;
            else if (i < 10) ep = i == 8 ? vic_pkg::STD_PAL_BGHID : vic_pkg::STD_PAL_N;
            else ep = i < 12 ? vic_pkg::STD_PAL_M : vic_pkg::STD_PAL_CN;
            `CHK("standard", {i < 4, ep, en, i[0] && i != 8}, {aut, pal, nts, ped})
            ps = s;
        end
        // Genlocked source, no reacquire
        wr(8'h04, 8'h80);
        n0 = racq_seen;
        wr(8'h00, 8'h05);
        `CHK("no reacquire", 0, racq_seen - n0)
        rd("status", 8'h0C, {1'b1, 4'h0, vic_pkg::FMT_COMPOSITE, 1'b1}, 1'b0);
        wr(8'h0C, 8'h80);
        rd("status clear", 8'h0C, {5'h00, vic_pkg::FMT_COMPOSITE, 1'b1}, 1'b0);
        // Peaking and coring codes
        for (int p = 0; p < 8; p++) begin
            wr(8'h08, {3'b000, 2'(p % 4), 3'(p)});
            `CHK("gain", {12'(pgc[p]), 12'(pgs[p])}, {gc, gs})
            `CHK("coring", {p % 4 != 0, p % 4 == 0 ? 6'h00 : 6'h04 << (p % 4)}, {cen, thr})
            `CHK("peak mode", 3'(p), pm)
            rd("enh readback", 8'h08, {3'b000, 2'(p % 4), 3'(p)}, 1'b0);
        end
        // Unmapped address refused
        wr(8'h10, 8'hFF);
        rd("unmapped", 8'h10, 8'h00, 1'b1);
        rd("input kept", 8'h00, 8'h05, 1'b0);
        report_and_stop();
    end
endmodule : vic_regs_tb
